//--- include/isa_pkg.sv
// Package for the I2C slave address match and interrupt block
package isa_pkg;

  // ****************************************************************
  // Register offsets (word index on the register port)
  // ****************************************************************
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0]  OFS_IE2  = 4'h0;
  localparam logic [3:0]  OFS_SLA0 = 4'h1;
  localparam logic [3:0]  OFS_SLA3 = 4'h4;
  localparam logic [3:0]  OFS_CTRL = 4'h5;
  localparam logic [3:0]  OFS_FLAG = 4'h6;
  localparam logic [3:0]  OFS_FSET = 4'h7;
  localparam logic [3:0]  OFS_MPTR = 4'h8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned BIT_STOP   = 5;
  localparam int unsigned BIT_ASTART = 4;
  localparam int unsigned BIT_MADDR  = 3;
  localparam int unsigned BIT_AMATCH = 1;
  localparam int unsigned CTL_EN2    = 0;
  localparam int unsigned CTL_ACK    = 3;
  localparam int unsigned CTL_AMIE   = 4;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [15:0] RST_IE2   = 16'h0000;
  localparam logic [7:0]  RST_SLA0  = 8'h36;
  localparam logic [7:0]  RST_SLAX  = 8'h00;
  localparam logic [15:0] RST_CTRL  = 16'h0000;
  localparam logic [15:0] RST_FLAG  = 16'h0000;
  localparam logic [7:0]  RST_MPTR  = 8'h00;
  localparam logic [15:0] MSK_IE2   = 16'h0038;
  localparam logic [15:0] MSK_CTRL  = 16'h001F;
  localparam logic [15:0] MSK_FLAG  = 16'h003A;

  // ****************************************************************
  // Counts
  // ****************************************************************
  localparam logic [3:0] BYTE_CLKS  = 4'h8;
  localparam logic [1:0] ASTART_CLKS = 2'h2;

  // Register port request
  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    logic [15:0]         wdata;
  } isa_req_t;

  // Bus engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK_A = 3'b010,
    ST_DATA  = 3'b011,
    ST_ACK_D = 3'b100,
    ST_SKIP  = 3'b101
  } isa_state_t;

endpackage

//--- hw/isa_core.sv
// I2C slave address comparators, memory address capture and event interrupts
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
// Notes on behaviour
// - STOP interrupt only while its enable set
// - Interrupt after START plus two clocks
// - Byte after write match becomes memory pointer
// - Compare address, acknowledge with ack_value_bit
// - Address match sets addr_match_flag, interrupts
// - Primary comparator always on, resets 36h
// - Extra comparators need enables, reset zero
// - Bit 0 takes received direction bit
// - STOP flag sticky, software sets or clears
// - Memory address byte sets mem_addr_flag
module isa_core (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // Register port
  input  wire isa_pkg::isa_req_t req_i,
  output logic [15:0]            rdata_o,
  // I2C pins, open drain
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  // Interrupt
  output logic                   irq_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic scl_meta, scl_s, scl_d;
  logic sda_meta, sda_s, sda_d;

  // Three flops; the second and third are looked at
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      scl_d    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      scl_s    <= scl_meta;
      scl_d    <= scl_s;
      sda_meta <= sda_i;
      sda_s    <= sda_meta;
      sda_d    <= sda_s;
    end
  end

  // Bus conditions
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] ie2;
  logic [7:0]  sla [0:3];
  logic [15:0] ctrl;
  logic [15:0] flags;
  logic [7:0]  mem_ptr;

  // Comparator: enabled and bits 7:1 equal
  function automatic logic cmp(input logic en, input logic [7:0] a,
                               input logic [7:0] rx);
    cmp = en & (a[7:1] == rx[7:1]);
  endfunction

  logic       wr_ie2, wr_ctrl, wr_flag, wr_fset;
  assign wr_ie2  = req_i.wr & (req_i.addr == isa_pkg::OFS_IE2);
  assign wr_ctrl = req_i.wr & (req_i.addr == isa_pkg::OFS_CTRL);
  assign wr_flag = req_i.wr & (req_i.addr == isa_pkg::OFS_FLAG);
  assign wr_fset = req_i.wr & (req_i.addr == isa_pkg::OFS_FSET);

  // ****************************************************************
  // Bus engine
  // ****************************************************************
  isa_pkg::isa_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [3:0] match_vec;
  logic       byte_done;
  logic       ev_amatch, ev_maddr, ev_astart;
  logic [1:0] astart_cnt;
  logic       astart_arm;

  always_comb begin
    match_vec[0] = cmp(1'b1, sla[0], shift);
    for (int i = 1; i < 4; i++) begin
      match_vec[i] = cmp(ctrl[isa_pkg::CTL_EN2 + i - 1], sla[i], shift);
    end
  end

  assign byte_done = scl_fall & (bit_cnt == isa_pkg::BYTE_CLKS);
  assign ev_amatch = (state == isa_pkg::ST_ADDR) & byte_done & (|match_vec);
  assign ev_maddr  = (state == isa_pkg::ST_DATA) & byte_done;

  // State, shifter and acknowledge drive
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= isa_pkg::ST_IDLE;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      sda_oe_o <= 1'b0;
    end else if (stop_det) begin
      state    <= isa_pkg::ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state    <= isa_pkg::ST_ADDR;
      bit_cnt  <= 4'h0;
      sda_oe_o <= 1'b0;
    end else begin
      unique case (state)
        isa_pkg::ST_ADDR, isa_pkg::ST_DATA: begin
          if (scl_rise && bit_cnt != isa_pkg::BYTE_CLKS) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (ev_amatch || ev_maddr) begin
            state    <= ev_amatch ? isa_pkg::ST_ACK_A : isa_pkg::ST_ACK_D;
            sda_oe_o <= ~ctrl[isa_pkg::CTL_ACK];
          end else if (byte_done) begin
            state <= isa_pkg::ST_SKIP;
          end
        end
        isa_pkg::ST_ACK_A: begin
          // write direction goes on to memory address
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            bit_cnt  <= 4'h0;
            state    <= shift[0] ? isa_pkg::ST_SKIP : isa_pkg::ST_DATA;
          end
        end
        isa_pkg::ST_ACK_D: begin
          // Later data bytes belong to the buffer logic
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            state    <= isa_pkg::ST_SKIP;
          end
        end
        isa_pkg::ST_IDLE, isa_pkg::ST_SKIP: begin
          sda_oe_o <= 1'b0;
        end
        default: begin
          state    <= isa_pkg::ST_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      astart_cnt <= 2'h0;
      astart_arm <= 1'b0;
    end else if (start_det) begin
      astart_cnt <= 2'h0;
      astart_arm <= 1'b1;
    end else if (stop_det || ev_astart) begin
      astart_arm <= 1'b0;
    end else if (astart_arm && scl_rise) begin
      astart_cnt <= astart_cnt + 2'h1;
    end
  end
  assign ev_astart = astart_arm & (astart_cnt == isa_pkg::ASTART_CLKS);

  // ****************************************************************
  // Software registers
  // ****************************************************************

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ie2  <= isa_pkg::RST_IE2;
      ctrl <= isa_pkg::RST_CTRL;
    end else begin
      if (wr_ie2) ie2 <= req_i.wdata & isa_pkg::MSK_IE2;
      if (wr_ctrl) ctrl <= req_i.wdata & isa_pkg::MSK_CTRL;
    end
  end

  // address registers, hardware owns bit 0 on a match
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sla[0] <= isa_pkg::RST_SLA0;
      for (int i = 1; i < 4; i++) sla[i] <= isa_pkg::RST_SLAX;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ev_amatch && match_vec[i]) begin
          sla[i][0] <= shift[0];
        end else if (req_i.wr && req_i.addr == isa_pkg::OFS_SLA0 + 4'(i)) begin
          sla[i] <= req_i.wdata[7:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ptr <= isa_pkg::RST_MPTR;
    end else if (ev_maddr) begin
      mem_ptr <= shift;
    end
  end

  // ****************************************************************
  // Flags and interrupt
  // ****************************************************************
  logic [15:0] hw_set, next_flags, en_vec;

  // bus events that set their flags
  always_comb begin
    hw_set                      = 16'h0000;
    hw_set[isa_pkg::BIT_STOP]   = stop_det;
    hw_set[isa_pkg::BIT_ASTART] = ev_astart;
    hw_set[isa_pkg::BIT_MADDR]  = ev_maddr;
    hw_set[isa_pkg::BIT_AMATCH] = ev_amatch;
  end

  // set wins over write-one-clear; set port raises flag
  always_comb begin
    next_flags = flags & ~(wr_flag ? req_i.wdata : 16'h0000);
    next_flags = next_flags | (wr_fset ? req_i.wdata : 16'h0000) | hw_set;
    next_flags = next_flags & isa_pkg::MSK_FLAG;
  end

  // flags are sticky until software clears
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags <= isa_pkg::RST_FLAG;
    end else begin
      flags <= next_flags;
    end
  end

  // AND each flag with its enable, OR together
  always_comb begin
    en_vec                      = ie2;
    en_vec[isa_pkg::BIT_AMATCH] = ctrl[isa_pkg::CTL_AMIE];
  end
  assign irq_o = |(flags & en_vec);

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (!req_i.rd) begin
      rdata_o <= 16'h0000;
    end else begin
      unique case (req_i.addr)
        isa_pkg::OFS_IE2:  rdata_o <= ie2;
        4'h1, 4'h2, 4'h3, isa_pkg::OFS_SLA3:
          rdata_o <= {8'h00, sla[2'(req_i.addr - isa_pkg::OFS_SLA0)]};
        isa_pkg::OFS_CTRL: rdata_o <= ctrl;
        isa_pkg::OFS_FLAG: rdata_o <= flags;
        isa_pkg::OFS_MPTR: rdata_o <= {8'h00, mem_ptr};
        default:           rdata_o <= 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [1:0] rises_since;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) rises_since <= 2'h0;
    else if (start_det) rises_since <= 2'h0;
    else if (scl_rise && rises_since != 2'h3) rises_since <= rises_since + 2'h1;
  end

  sequence seq_addr_done;
    ev_amatch && !stop_det && !start_det;
  endsequence
  sequence seq_ack_held;
    (state == isa_pkg::ST_ACK_A) && (sda_oe_o == ~$past(ctrl[isa_pkg::CTL_ACK]));
  endsequence

  // STOP with enable raises the line
  AST_STOP_IRQ: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    stop_det && ie2[isa_pkg::BIT_STOP] |=> irq_o)
    else $error("stop interrupt missing");
  AST_NO_EN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ie2 == 16'h0000 && !ctrl[isa_pkg::CTL_AMIE] |-> !irq_o)
    else $error("interrupt without enabled flag");
  // after-start event after exactly two rises
  AST_ASTART: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ev_astart |-> rises_since == 2'h2 ##1 flags[isa_pkg::BIT_ASTART])
    else $error("after start timing wrong");
  AST_ACK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    seq_addr_done |=> seq_ack_held)
    else $error("address acknowledge wrong");
  AST_AMATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    seq_addr_done |=> flags[isa_pkg::BIT_AMATCH])
    else $error("address match flag not set");
  // pointer and flag follow the memory byte
  AST_MPTR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ev_maddr |=> mem_ptr == $past(shift) && flags[isa_pkg::BIT_MADDR])
    else $error("memory pointer capture wrong");
  AST_EN2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ctrl[isa_pkg::CTL_EN2] |-> !match_vec[1])
    else $error("disabled comparator matched");
  // primary bit 0 takes direction bit
  AST_DIR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ev_amatch && match_vec[0] |=> sla[0][0] == $past(shift[0]))
    else $error("direction bit not recorded");
  AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    flags[isa_pkg::BIT_STOP] && !wr_flag |=> flags[isa_pkg::BIT_STOP])
    else $error("stop flag lost");
  // reserved bits 15:6 of enable register read zero
  AST_RSVD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    req_i.rd && req_i.addr == isa_pkg::OFS_IE2 |=> rdata_o[15:6] == 10'h000)
    else $error("reserved bits not zero");

endmodule // isa_core

//--- sim/isa_i2c_master.sv
// Behavioural I2C bus master that drives the link from the bus side
`timescale 1ns/1ns
module isa_i2c_master (
  // I2C pins, open drain
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  // ********
  // Bus idle
  // ********
  // Both lines released; clock stands high outside frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Data falls while the clock is high
  task automatic start();
    sda_oe_o = 1'b0;
    #63 sda_oe_o = 1'b1;
    // Odd length keeps later pin moves off the bench clock edges
    #63 scl_o = 1'b0;
  endtask
  // Data rises while the clock is high
  task automatic stop();
    #31 sda_oe_o = 1'b1;
    #32 scl_o = 1'b1;
    #62 sda_oe_o = 1'b0;
    #63;
  endtask
  // MSB first; data only moves mid low phase, never near the clock edges
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #31 sda_oe_o = ~b[i];
      #32 scl_o = 1'b1;
      #62 scl_o = 1'b0;
    end
    // Ninth clock: line released so the slave can answer
    #31 sda_oe_o = 1'b0;
    #32 scl_o = 1'b1;
    #31 ack = ~sda_i;
    #31 scl_o = 1'b0;
  endtask
endmodule // isa_i2c_master

//--- sim/test_isa_core.sv
// Self-checking bench for the I2C slave address match and interrupt block
`timescale 1ns/1ns
module test_isa_core;
  // ********
  // Signals
  // ********
  typedef struct packed {logic wr; logic [3:0] a; logic [15:0] d;} isa_row_t;
  logic              ref_clk_i;
  logic              rst_i;
  isa_pkg::isa_req_t req;
  logic [15:0]       rdata;
  logic              scl;
  logic              sda;
  logic              sda_drv;
  logic              d_oe;
  logic              m_oe;
  logic              irq;
  logic              ack;
  int                n_errors;
  int                samples_checked;
  int                cycles;
  // Register rows: writes carry data, reads carry the expected word
  // Writes keep reserved bits at zero, except the all-ones write to unused offset F
  isa_row_t rows [16] = '{
    '{1'h0, 4'h1, 16'h0036}, '{1'h0, 4'h2, 16'h0000}, '{1'h0, 4'h3, 16'h0000},
    '{1'h0, 4'h4, 16'h0000}, '{1'h0, 4'h0, 16'h0000}, '{1'h0, 4'h5, 16'h0000},
    '{1'h0, 4'h6, 16'h0000}, '{1'h0, 4'h8, 16'h0000}, '{1'h1, 4'h0, 16'h0038},
    '{1'h0, 4'h0, 16'h0038}, '{1'h1, 4'h4, 16'h00FF}, '{1'h0, 4'h4, 16'h00FF},
    '{1'h1, 4'hF, 16'hFFFF}, '{1'h0, 4'hF, 16'h0000}, '{1'h1, 4'h0, 16'h0000},
    '{1'h1, 4'h4, 16'h0000}};

  // Open-drain data line with pull-up; clock comes from the master only
  assign sda = ~m_oe & (~d_oe | sda_drv);

  isa_core i_isa_core (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .req_i     (req),
    .rdata_o   (rdata),
    .scl_i     (scl),
    .sda_i     (sda),
    .sda_o     (sda_drv),
    .sda_oe_o  (d_oe),
    .irq_o     (irq)
  );

  isa_i2c_master i_isa_i2c_master (
    .scl_o    (scl),
    .sda_oe_o (m_oe),
    .sda_i    (sda)
  );

  // ********
  // Tasks
  // ********
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge ref_clk_i);
    req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk_i);
    req.rd <= 1'b0;
    #1 check(nm, rdata, exp);
  endtask
  task automatic irq_chk(input logic exp);
    @(posedge ref_clk_i);
    #1 check("irq", {15'h0000, irq}, {15'h0000, exp});
  endtask
  task automatic xfer(input logic [7:0] b);
    i_isa_i2c_master.start();
    i_isa_i2c_master.send(b, ack);
    i_isa_i2c_master.stop();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ********
  // Clock and watchdog
  // ********
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Ceiling well above the two thousand or so cycles the tests need
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      conclude();
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    rst_i = 1'b1;
    req = '0;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr)
        reg_wr(rows[i].a, rows[i].d);
      else
        rd_chk("reg", rows[i].a, rows[i].d);
    end
    $display("register table done");
    // Write to primary address, then memory byte, all events enabled
    reg_wr(isa_pkg::OFS_CTRL, 16'h0010);
    reg_wr(isa_pkg::OFS_IE2, 16'h0038);
    i_isa_i2c_master.start();
    i_isa_i2c_master.send(8'h36, ack);
    check("ack", {15'h0000, ack}, 16'h0001);
    irq_chk(1'b1);
    rd_chk("flags", isa_pkg::OFS_FLAG, 16'h0012);
    rd_chk("sla0", isa_pkg::OFS_SLA0, 16'h0036);
    i_isa_i2c_master.send(8'hA5, ack);
    check("ack", {15'h0000, ack}, 16'h0001);
    rd_chk("mptr", isa_pkg::OFS_MPTR, 16'h00A5);
    rd_chk("flags", isa_pkg::OFS_FLAG, 16'h001A);
    i_isa_i2c_master.stop();
    rd_chk("flags", isa_pkg::OFS_FLAG, 16'h003A);
    reg_wr(isa_pkg::OFS_FLAG, 16'h003A);
    rd_chk("flags", isa_pkg::OFS_FLAG, 16'h0000);
    irq_chk(1'b0);
    $display("write transfer done");
    // Read direction with every enable off: flags rise, no request
    reg_wr(isa_pkg::OFS_IE2, 16'h0000);
    reg_wr(isa_pkg::OFS_CTRL, 16'h0000);
    xfer(8'h37);
    check("ack", {15'h0000, ack}, 16'h0001);
    rd_chk("sla0", isa_pkg::OFS_SLA0, 16'h0037);
    rd_chk("flags", isa_pkg::OFS_FLAG, 16'h0032);
    irq_chk(1'b0);
    reg_wr(isa_pkg::OFS_IE2, 16'h0020);
    irq_chk(1'b1);
    reg_wr(isa_pkg::OFS_FLAG, 16'h003A);
    irq_chk(1'b0);
    reg_wr(isa_pkg::OFS_FSET, 16'h0020);
    irq_chk(1'b1);
    reg_wr(isa_pkg::OFS_IE2, 16'h0010);
    irq_chk(1'b0);
    reg_wr(isa_pkg::OFS_FLAG, 16'h003A);
    $display("masking done");
    // Extra comparators: ignored while disabled, then ack level obeyed
    for (int k = 0; k < 3; k++) begin
      reg_wr(4'(k + 2), {8'h00, 8'(8'h50 + 2 * k)});
      reg_wr(isa_pkg::OFS_CTRL, 16'h0000);
      xfer(8'(8'h50 + 2 * k));
      check("ack", {15'h0000, ack}, 16'h0000);
      rd_chk("flags", isa_pkg::OFS_FLAG, 16'h0030);
      reg_wr(isa_pkg::OFS_CTRL, 16'(1 << k));
      xfer(8'(8'h50 + 2 * k));
      check("ack", {15'h0000, ack}, 16'h0001);
      reg_wr(isa_pkg::OFS_CTRL, 16'(1 << k) | 16'h0008);
      xfer(8'(8'h50 + 2 * k));
      check("ack", {15'h0000, ack}, 16'h0000);
      rd_chk("flags", isa_pkg::OFS_FLAG, 16'h0032);
      reg_wr(isa_pkg::OFS_FLAG, 16'h003A);
    end
    $display("extra comparators done");
    // Reset in mid-run restores the primary address
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_chk("sla0", isa_pkg::OFS_SLA0, 16'h0036);
    rd_chk("sla1", 4'h2, 16'h0000);
    $display("second reset done");
    conclude();
  end
endmodule // test_isa_core
